// *** aboe_pkg.sv ***
// shared constants, types and helpers for the add/and/bit execution block
package aboe_pkg;

	// clocks per instruction cycle
	localparam int unsigned CYC_DIV    = 4;

	// apb byte offsets
	localparam logic [7:0]  OFF_INSTR  = 8'h00;
	localparam logic [7:0]  OFF_WREG   = 8'h04;
	localparam logic [7:0]  OFF_STATUS = 8'h08;
	localparam logic [7:0]  OFF_FADDR  = 8'h0c;
	localparam logic [7:0]  OFF_FDATA  = 8'h10;

	// status bit positions
	localparam int unsigned ST_C       = 0;
	localparam int unsigned ST_DC      = 1;
	localparam int unsigned ST_Z       = 2;
	localparam int unsigned ST_SKIP    = 3;
	localparam int unsigned ST_BUSY    = 4;

	// file address of the pin port
	localparam logic [6:0]  GPIO_ADDR  = 7'h05;

	// reset values
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [6:0]  FADDR_RST  = 7'h00;

	typedef logic [7:0]  aboe_paddr_t;
	typedef logic [31:0] aboe_word_t;
	typedef logic [7:0]  aboe_byte_t;

	typedef enum logic [3:0]
	{
		OP_NOP        = 4'h0,
		OP_ADD_IMM    = 4'h1,
		OP_AND_IMM    = 4'h2,
		OP_ADD_FILE   = 4'h3,
		OP_AND_FILE   = 4'h4,
		OP_BIT_ZERO   = 4'h5,
		OP_BIT_ONE    = 4'h6,
		OP_SKIP_ONE   = 4'h7,
		OP_SKIP_ZERO  = 4'h8
	} aboe_op_t;

	// instruction word layout, op in the low bits
	typedef struct packed
	{
		logic [7:0] lit;
		logic [6:0] addr;
		logic [2:0] bitsel;
		logic       dest;
		aboe_op_t   op;
	} aboe_ins_t;

	typedef struct packed
	{
		logic z;
		logic dc;
		logic c;
	} aboe_flags_t;

	typedef struct packed
	{
		logic       c;
		logic       dc;
		logic [7:0] sum;
	} aboe_add_t;

	typedef enum logic [1:0]
	{
		EX_IDLE = 2'b00,
		EX_READ = 2'b01,
		EX_CALC = 2'b10
	} aboe_ex_t;

	function automatic aboe_add_t aboe_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] l;
		s = {1'b0, a} + {1'b0, b};
		l = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		return '{c: s[8], dc: l[4], sum: s[7:0]};
	endfunction : aboe_add

	function automatic logic [7:0] aboe_mask(input logic [2:0] i);
		return 8'h01 << i;
	endfunction : aboe_mask

endpackage : aboe_pkg

// *** aboe_sync.sv ***
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module aboe_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] q_ff;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_ff <= '0;
			q_ff    <= '0;
		end
		else
		begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : aboe_sync

// *** aboe_mem.sv ***
// file register memory with registered read data
`timescale 1ns/1ps
module aboe_mem #(
	parameter int unsigned AW = 7,
	parameter int unsigned DW = 8
) (
	input  wire logic          clk,
	input  wire logic [AW-1:0] addr,
	input  wire logic          re,
	input  wire logic          we,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_ff;

	always_ff @(posedge clk)
	begin
		if (we)
			mem[addr] <= wdata;
		if (re)
			rdata_ff <= mem[addr];
	end

	assign rdata = rdata_ff;
endmodule : aboe_mem

// *** aboe_top.sv ***
// add/and/bit-op execution unit with apb registers and pin port
//
// How it works
// RQ1: add-immediate adds the 8-bit literal to w, result in w, c dc z updated.
// RQ2: and-immediate ands w with the literal into w and updates only z.
// RQ3: add-to-file adds w to the addressed file register, result to the destination, c dc z updated.
// RQ4: and-with-file ands w with the addressed file register, result to the destination, only z updated.
// RQ5: destination bit 0 sends the result to w, 1 writes it back into the file register.
// RQ6: bit-force-zero clears the indexed bit of the file register and leaves the flags alone.
// RQ7: bit-force-one sets the indexed bit, all other bits and flags unchanged.
// RQ8: skip-when-bit-one discards the next instruction as a nop when the bit is one, no flags change.
// RQ9: skip-when-bit-zero discards the next instruction as a nop when the bit is zero, no flags change.
// RQ10: read-modify-write on the pin port operates on the synchronised pin levels, not the latch.
// RQ11: z is set for an all-zero result, c is carry out of bit 7 and dc carry out of bit 3.
// RQ12: every instruction except a taken skip completes within one instruction cycle.
`timescale 1ns/1ps
module aboe_top (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire aboe_pkg::aboe_paddr_t paddr,
	input  wire aboe_pkg::aboe_word_t  pwdata,
	output aboe_pkg::aboe_word_t       prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire aboe_pkg::aboe_byte_t  gpio_pin_in,
	output aboe_pkg::aboe_byte_t       gpio_out
);
	import aboe_pkg::*;

	localparam int unsigned CNT_W = $clog2(CYC_DIV);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	logic [CNT_W-1:0] cyc_cnt_ff;
	logic             cyc_en;
	aboe_ins_t        ins_ff;
	aboe_ins_t        cur_ff;
	logic             pend_ff;
	logic             skip_ff;
	aboe_ex_t         ex_ff;
	aboe_byte_t       w_ff;
	aboe_flags_t      flg_ff;
	logic [6:0]       faddr_ff;
	aboe_byte_t       gpio_ff;
	aboe_word_t       prdata_ff;
	logic             pready_ff;
	logic             pslverr_ff;
	logic             fd_rd_ff;
	aboe_byte_t       pin_q;
	aboe_byte_t       mem_rd;
	logic [6:0]       mem_addr;
	logic             mem_re;
	logic             mem_we;
	aboe_byte_t       mem_wd;
	logic             start;
	logic             busy;
	logic             calc;
	logic             mem_free;
	aboe_byte_t       opnd;
	aboe_byte_t       opnd_b;
	aboe_byte_t       res;
	aboe_add_t        sum_s;
	logic             to_w;
	logic             file_we;
	logic             upd_cdc;
	logic             upd_z;
	logic             skip_set;
	logic             acc;
	logic             hit;
	logic             can;
	logic             go;
	logic             fd_issue;
	aboe_word_t       rd_val;
	logic [3:0]       w_lo;
	logic [3:0]       b_lo;

	aboe_sync #(.WIDTH(8)) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (gpio_pin_in),
		.q     (pin_q)
	);

	aboe_mem #(.AW(7), .DW(8)) u_mem (
		.clk   (clk),
		.addr  (mem_addr),
		.re    (mem_re),
		.we    (mem_we),
		.wdata (mem_wd),
		.rdata (mem_rd)
	);

	// instruction cycle enable
	assign cyc_en = (cyc_cnt_ff == CNT_W'(CYC_DIV - 1));

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cyc_cnt_ff <= '0;
		else if (cyc_en)
			cyc_cnt_ff <= '0;
		else
			cyc_cnt_ff <= cyc_cnt_ff + CNT_W'(1);
	end

	assign start    = cyc_en && pend_ff && (ex_ff == EX_IDLE);
	assign busy     = pend_ff || (ex_ff != EX_IDLE);
	assign calc     = (ex_ff == EX_CALC);
	assign mem_free = (ex_ff == EX_IDLE) && !start;

	// sequencer: start, read operand, compute and write back
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ex_ff <= EX_IDLE;
		else
			unique case (ex_ff)
				EX_IDLE: if (start && !skip_ff) ex_ff <= EX_READ; // [RQ12] [RQ8] [RQ9]
				EX_READ: ex_ff <= EX_CALC;
				EX_CALC: ex_ff <= EX_IDLE;
				default: ex_ff <= EX_IDLE;
			endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cur_ff <= '0;
		else if (start)
			cur_ff <= ins_ff;
	end

	// taken skip turns the next instruction into a nop cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			skip_ff <= 1'b0;
		else if (calc && skip_set)
			skip_ff <= 1'b1; // [RQ8] [RQ9]
		else if (start)
			skip_ff <= 1'b0;
	end

	// operand: pins for the port address, else file memory
	assign opnd   = (cur_ff.addr == GPIO_ADDR) ? pin_q : mem_rd; // [RQ10]
	assign opnd_b = (cur_ff.op == OP_ADD_IMM || cur_ff.op == OP_AND_IMM) ? cur_ff.lit : opnd;
	assign sum_s  = aboe_add(w_ff, opnd_b); // [RQ11]
	assign w_lo   = w_ff[3:0];
	assign b_lo   = opnd_b[3:0];

	always_comb
	begin
		res      = BYTE_RST;
		to_w     = 1'b0;
		file_we  = 1'b0;
		upd_cdc  = 1'b0;
		upd_z    = 1'b0;
		skip_set = 1'b0;
		unique case (cur_ff.op)
			OP_ADD_IMM:
			begin
				res     = sum_s.sum; // [RQ1]
				to_w    = 1'b1;
				upd_cdc = 1'b1;
				upd_z   = 1'b1;
			end
			OP_AND_IMM:
			begin
				res   = w_ff & cur_ff.lit; // [RQ2]
				to_w  = 1'b1;
				upd_z = 1'b1;
			end
			OP_ADD_FILE:
			begin
				res     = sum_s.sum; // [RQ3]
				to_w    = !cur_ff.dest; // [RQ5]
				file_we = cur_ff.dest;
				upd_cdc = 1'b1;
				upd_z   = 1'b1;
			end
			OP_AND_FILE:
			begin
				res     = w_ff & opnd; // [RQ4]
				to_w    = !cur_ff.dest; // [RQ5]
				file_we = cur_ff.dest;
				upd_z   = 1'b1;
			end
			OP_BIT_ZERO:
			begin
				res     = opnd & ~aboe_mask(cur_ff.bitsel); // [RQ6]
				file_we = 1'b1;
			end
			OP_BIT_ONE:
			begin
				res     = opnd | aboe_mask(cur_ff.bitsel); // [RQ7]
				file_we = 1'b1;
			end
			OP_SKIP_ONE:  skip_set = opnd[cur_ff.bitsel]; // [RQ8]
			OP_SKIP_ZERO: skip_set = !opnd[cur_ff.bitsel]; // [RQ9]
			default:      skip_set = 1'b0;
		endcase
	end

	// apb decode
	assign acc      = psel && penable && !pready_ff;
	assign go       = acc && can;
	assign fd_issue = acc && (paddr == OFF_FDATA) && !pwrite && !fd_rd_ff && mem_free;

	always_comb
	begin
		hit    = 1'b1;
		can    = 1'b1;
		rd_val = '0;
		unique case (paddr)
			OFF_INSTR:
			begin
				can    = !pwrite || !pend_ff;
				rd_val = {9'h000, ins_ff};
			end
			OFF_WREG:
			begin
				can    = !pwrite || !busy;
				rd_val = {24'h000000, w_ff};
			end
			OFF_STATUS:
			begin
				can    = !pwrite || !busy;
				rd_val = {27'h0000000, busy, skip_ff, flg_ff.z, flg_ff.dc, flg_ff.c};
			end
			OFF_FADDR:  rd_val = {25'h0000000, faddr_ff};
			OFF_FDATA:
			begin
				can    = pwrite ? mem_free : fd_rd_ff;
				rd_val = {24'h000000, (faddr_ff == GPIO_ADDR) ? pin_q : mem_rd};
			end
			default:    hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end
		else
		begin
			pready_ff  <= go;
			pslverr_ff <= go && !hit;
			if (go)
				prdata_ff <= rd_val;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			fd_rd_ff <= 1'b0;
		else if (go)
			fd_rd_ff <= 1'b0;
		else if (fd_issue)
			fd_rd_ff <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ins_ff  <= '0;
			pend_ff <= 1'b0;
		end
		else if (go && pwrite && paddr == OFF_INSTR)
		begin
			ins_ff  <= pwdata[22:0];
			pend_ff <= 1'b1;
		end
		else if (start)
			pend_ff <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			faddr_ff <= FADDR_RST;
		else if (go && pwrite && paddr == OFF_FADDR)
			faddr_ff <= pwdata[6:0];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			w_ff <= BYTE_RST;
		else if (calc && to_w)
			w_ff <= res; // [RQ5]
		else if (go && pwrite && paddr == OFF_WREG)
			w_ff <= pwdata[7:0];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			flg_ff <= '0;
		else if (calc)
		begin
			if (upd_cdc)
			begin
				flg_ff.c  <= sum_s.c; // [RQ11]
				flg_ff.dc <= sum_s.dc;
			end
			if (upd_z)
				flg_ff.z <= (res == BYTE_RST); // [RQ11]
		end
		else if (go && pwrite && paddr == OFF_STATUS)
			flg_ff <= {pwdata[ST_Z], pwdata[ST_DC], pwdata[ST_C]};
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			gpio_ff <= BYTE_RST;
		else if (calc && file_we && cur_ff.addr == GPIO_ADDR)
			gpio_ff <= res; // [RQ10]
		else if (go && pwrite && paddr == OFF_FDATA && faddr_ff == GPIO_ADDR)
			gpio_ff <= pwdata[7:0];
	end

	// memory port shared between sequencer and register access
	always_comb
	begin
		mem_addr = faddr_ff;
		mem_re   = fd_issue;
		mem_we   = go && pwrite && (paddr == OFF_FDATA) && (faddr_ff != GPIO_ADDR);
		mem_wd   = pwdata[7:0];
		if (ex_ff == EX_READ)
		begin
			mem_addr = cur_ff.addr;
			mem_re   = 1'b1;
			mem_we   = 1'b0;
		end
		else if (calc)
		begin
			mem_addr = cur_ff.addr;
			mem_re   = 1'b0;
			mem_we   = file_we && (cur_ff.addr != GPIO_ADDR); // [RQ5]
			mem_wd   = res;
		end
	end

	assign prdata   = prdata_ff;
	assign pready   = pready_ff;
	assign pslverr  = pslverr_ff;
	assign gpio_out = gpio_ff;

	a_add_imm_w: assert property (calc && cur_ff.op == OP_ADD_IMM |=> w_ff == 8'($past(w_ff) + $past(cur_ff.lit))) // [RQ1]
		else $error("add immediate result wrong");
	a_and_imm_keep: assert property (calc && cur_ff.op == OP_AND_IMM |=> flg_ff.c == $past(flg_ff.c) && flg_ff.dc == $past(flg_ff.dc) && w_ff == ($past(w_ff) & $past(cur_ff.lit))) // [RQ2]
		else $error("and immediate touched carry or gave wrong w");
	a_add_file_w: assert property (calc && cur_ff.op == OP_ADD_FILE && !cur_ff.dest |=> w_ff == 8'($past(w_ff) + $past(opnd))) // [RQ3]
		else $error("add to file into w wrong");
	a_file_dest_one: assert property (calc && (cur_ff.op == OP_ADD_FILE || cur_ff.op == OP_AND_FILE) && cur_ff.dest |=> $stable(w_ff)) // [RQ5]
		else $error("file destination changed w");
	a_and_file_res: assert property (calc && cur_ff.op == OP_AND_FILE && cur_ff.dest && cur_ff.addr != GPIO_ADDR |-> mem_we && mem_wd == (w_ff & opnd)) // [RQ4]
		else $error("and with file write back wrong");
	a_bit_zero_op: assert property (calc && cur_ff.op == OP_BIT_ZERO |-> !res[cur_ff.bitsel] ##1 $stable(flg_ff)) // [RQ6]
		else $error("bit force zero failed or touched flags");
	a_bit_one_op: assert property (calc && cur_ff.op == OP_BIT_ONE |-> (res == (opnd | aboe_mask(cur_ff.bitsel))) ##1 $stable(flg_ff)) // [RQ7]
		else $error("bit force one changed other bits or flags");
	a_skip_one_set: assert property (calc && cur_ff.op == OP_SKIP_ONE |=> skip_ff == $past(opnd[cur_ff.bitsel]) && $stable(flg_ff)) // [RQ8]
		else $error("skip when bit one mis-set");
	a_skip_zero_set: assert property (calc && cur_ff.op == OP_SKIP_ZERO |=> skip_ff == !$past(opnd[cur_ff.bitsel]) && $stable(flg_ff)) // [RQ9]
		else $error("skip when bit zero mis-set");
	a_skip_discard: assert property (start && skip_ff |=> ex_ff == EX_IDLE && !skip_ff && $stable(w_ff) [*2]) // [RQ8]
		else $error("skipped instruction was not discarded");
	a_rmw_pins: assert property (calc && cur_ff.addr == GPIO_ADDR |-> opnd == pin_q) // [RQ10]
		else $error("port operand not taken from pins");
	a_carry_flags: assert property (calc && upd_cdc |=> flg_ff.c == ((9'($past(w_ff)) + 9'($past(opnd_b))) > 9'h0ff) && flg_ff.dc == ((5'($past(w_lo)) + 5'($past(b_lo))) > 5'h0f)) // [RQ11]
		else $error("carry or digit carry wrong");
	a_zero_flag: assert property (calc && upd_z |=> flg_ff.z == ($past(res) == 8'h00)) // [RQ11]
		else $error("zero flag wrong");
	a_one_cycle: assert property (start && !skip_ff |=> ex_ff == EX_READ ##1 ex_ff == EX_CALC ##1 ex_ff == EX_IDLE) // [RQ12]
		else $error("instruction exceeded one instruction cycle");

	c_skip_taken: cover property (calc && skip_set ##[1:8] start && skip_ff);
	c_gpio_rmw: cover property (calc && file_we && cur_ff.addr == GPIO_ADDR);
	c_add_carry: cover property (calc && upd_cdc && sum_s.c && res == 8'h00);
endmodule : aboe_top

// *** tb_alu_bit_op_execute.sv ***
// self-checking testbench for the add/and/bit execution unit
`timescale 1ns/1ps
module tb_alu_bit_op_execute;
	import aboe_pkg::*;

	logic        clk;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	aboe_paddr_t paddr;
	aboe_word_t  pwdata;
	aboe_word_t  prdata;
	logic        pready;
	logic        pslverr;
	aboe_byte_t  gpio_pin_in;
	aboe_byte_t  gpio_out;
	int          miscompares;
	int          total_checks;

	aboe_top i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gpio_pin_in(gpio_pin_in), .gpio_out(gpio_out));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic close_out;
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic check(input string name, input aboe_word_t seen, input aboe_word_t exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input aboe_paddr_t a, input aboe_word_t d, output aboe_word_t q,
		output logic err);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 200);
		if (pready !== 1'b1)
		begin
			miscompares++;
			close_out();
		end
		q       = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input aboe_paddr_t a, input aboe_word_t d);
		aboe_word_t q;
		logic       e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input aboe_paddr_t a, output aboe_word_t q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask : rd

	function automatic aboe_word_t ins(aboe_op_t op, logic d, logic [2:0] b, logic [6:0] a, aboe_byte_t k);
		aboe_ins_t i;
		i.op     = op;
		i.dest   = d;
		i.bitsel = b;
		i.addr   = a;
		i.lit    = k;
		return {9'h0, i};
	endfunction : ins

	// issue one instruction and wait until the unit is idle again
	task automatic exec(input aboe_word_t w);
		aboe_word_t s;
		int         n;
		wr(OFF_INSTR, w);
		n = 0;
		do
		begin
			rd(OFF_STATUS, s);
			n++;
		end
		while (s[ST_BUSY] !== 1'b0 && n < 40);
		if (s[ST_BUSY] !== 1'b0)
		begin
			miscompares++;
			close_out();
		end
	endtask : exec

	task automatic state(input string n, input aboe_byte_t w, input logic [3:0] f);
		aboe_word_t q;
		rd(OFF_WREG, q);
		check({n, "_w"}, q, {24'h0, w});
		rd(OFF_STATUS, q);
		check({n, "_st"}, q, {28'h0, f});
	endtask : state

	task automatic t_reset;
		aboe_word_t q;
		logic       e;
		state("rst", 8'h00, 4'h0);
		rd(OFF_FADDR, q);
		check("faddr_rst", q, 32'h0);
		check("gpio_rst", {24'h0, gpio_out}, 32'h0);
		apb(1'b0, 8'h14, 32'h0, q, e);
		check("unmapped_err", {31'h0, e}, 32'h1);
		check("unmapped_data", q, 32'h0);
	endtask : t_reset

	task automatic t_add_imm;
		aboe_byte_t wv[4] = '{8'hff, 8'h0f, 8'h80, 8'h12};
		aboe_byte_t kv[4] = '{8'h01, 8'h01, 8'h80, 8'h34};
		logic [8:0] s;
		logic [4:0] l;
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_WREG, {24'h0, wv[i]});
			wr(OFF_STATUS, 32'h0);
			exec(ins(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, kv[i]));
			s = {1'b0, wv[i]} + {1'b0, kv[i]};
			l = {1'b0, wv[i][3:0]} + {1'b0, kv[i][3:0]};
			state("add_imm", s[7:0], {1'b0, s[7:0] == 8'h00, l[4], s[8]});
		end
	endtask : t_add_imm

	task automatic t_and_imm;
		wr(OFF_WREG, 32'hf0);
		wr(OFF_STATUS, 32'h3);
		exec(ins(OP_AND_IMM, 1'b0, 3'h0, 7'h00, 8'h0f));
		state("and_imm_z", 8'h00, 4'h7);
		wr(OFF_WREG, 32'ha5);
		exec(ins(OP_AND_IMM, 1'b0, 3'h0, 7'h00, 8'h3c));
		state("and_imm", 8'h24, 4'h3);
	endtask : t_and_imm

	task automatic t_file;
		aboe_word_t q;
		wr(OFF_FADDR, 32'h7f);
		wr(OFF_FDATA, 32'h88);
		wr(OFF_WREG, 32'h99);
		wr(OFF_STATUS, 32'h0);
		exec(ins(OP_ADD_FILE, 1'b0, 3'h0, 7'h7f, 8'h00));
		state("add_file_w", 8'h21, 4'h3);
		rd(OFF_FDATA, q);
		check("add_file_keep", q, 32'h88);
		exec(ins(OP_ADD_FILE, 1'b1, 3'h0, 7'h7f, 8'h00));
		state("add_file_f", 8'h21, 4'h0);
		rd(OFF_FDATA, q);
		check("add_file_mem", q, 32'ha9);
		wr(OFF_WREG, 32'h56);
		exec(ins(OP_AND_FILE, 1'b1, 3'h0, 7'h7f, 8'h00));
		state("and_file_f", 8'h56, 4'h4);
		rd(OFF_FDATA, q);
		check("and_file_mem", q, 32'h00);
		wr(OFF_FADDR, 32'h00);
		wr(OFF_FDATA, 32'h3c);
		wr(OFF_WREG, 32'h0f);
		wr(OFF_STATUS, 32'h3);
		exec(ins(OP_AND_FILE, 1'b0, 3'h0, 7'h00, 8'h00));
		state("and_file_w", 8'h0c, 4'h3);
		rd(OFF_FDATA, q);
		check("and_file_keep", q, 32'h3c);
	endtask : t_file

	task automatic t_bits;
		aboe_word_t q;
		wr(OFF_FADDR, 32'h20);
		wr(OFF_STATUS, 32'h5);
		for (int b = 0; b < 8; b++)
		begin
			wr(OFF_FDATA, 32'hff);
			exec(ins(OP_BIT_ZERO, 1'b0, 3'(b), 7'h20, 8'h00));
			rd(OFF_FDATA, q);
			check("bit_zero", q, {24'h0, ~(8'h01 << b)});
			wr(OFF_FDATA, 32'h00);
			exec(ins(OP_BIT_ONE, 1'b0, 3'(b), 7'h20, 8'h00));
			rd(OFF_FDATA, q);
			check("bit_one", q, {24'h0, 8'h01 << b});
			rd(OFF_STATUS, q);
			check("bit_flags", q, 32'h5);
		end
	endtask : t_bits

	task automatic t_skip;
		aboe_op_t op;
		logic     bv;
		logic     tk;
		for (int j = 0; j < 4; j++)
		begin
			op = j[1] ? OP_SKIP_ZERO : OP_SKIP_ONE;
			bv = j[0];
			tk = (op == OP_SKIP_ONE) ? bv : !bv;
			wr(OFF_FADDR, 32'h30);
			wr(OFF_FDATA, bv ? 32'h08 : 32'hf7);
			wr(OFF_WREG, 32'h10);
			wr(OFF_STATUS, 32'h0);
			exec(ins(op, 1'b0, 3'h3, 7'h30, 8'h00));
			state("skip_test", 8'h10, {tk, 3'h0});
			exec(ins(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h01));
			state("skip_next", tk ? 8'h10 : 8'h11, 4'h0);
			exec(ins(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h01));
			state("skip_after", tk ? 8'h11 : 8'h12, 4'h0);
		end
	endtask : t_skip

	task automatic t_pins;
		aboe_word_t q;
		gpio_pin_in <= 8'h0f;
		wr(OFF_FADDR, {25'h0, GPIO_ADDR});
		wr(OFF_FDATA, 32'hf0);
		check("latch", {24'h0, gpio_out}, 32'hf0);
		rd(OFF_FDATA, q);
		check("pin_read", q, 32'h0f);
		exec(ins(OP_BIT_ONE, 1'b0, 3'h7, GPIO_ADDR, 8'h00));
		check("pin_bit_one", {24'h0, gpio_out}, 32'h8f);
		wr(OFF_WREG, 32'h3c);
		exec(ins(OP_AND_FILE, 1'b1, 3'h0, GPIO_ADDR, 8'h00));
		check("pin_and", {24'h0, gpio_out}, 32'h0c);
	endtask : t_pins

	initial
	begin
		miscompares  = 0;
		total_checks = 0;
		rst_b        = 1'b0;
		psel         = 1'b0;
		penable      = 1'b0;
		pwrite       = 1'b0;
		paddr        = 8'h00;
		pwdata       = 32'h0;
		gpio_pin_in  = 8'h00;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_add_imm();
		t_and_imm();
		t_file();
		t_bits();
		t_skip();
		t_pins();
		close_out();
	end

endmodule : tb_alu_bit_op_execute
